// File: iakr_cfg.svh
// addresses, field layouts, reset values and vectors of the interrupt acknowledge block
`ifndef IAKR_CFG_SVH
`define IAKR_CFG_SVH

`define IAKR_NUM_SRC      11
`define IAKR_KEY_PRIO     10
`define IAKR_KRSEL_ADDR   16'hfff5
`define IAKR_IFA_ADDR     16'hffe0
`define IAKR_IFB_ADDR     16'hffe1
`define IAKR_MKA_ADDR     16'hffe4
`define IAKR_MKB_ADDR     16'hffe5
`define IAKR_KRSEL_RST    8'h00
`define IAKR_KRSEL_WMASK  8'hf1
`define IAKR_KRSEL_LOW    0
`define IAKR_IF_RST       16'h0000
`define IAKR_MK_RST       16'hffff
`define IAKR_FLAG_USED    16'h7cf3
`define IAKR_POS_TABLE    {4'h4, 4'h7, 4'h6, 4'h5, 4'h1, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'h0}
`define IAKR_PSW_IE_BIT   7
`define IAKR_IE_RST       1'b0
`define IAKR_NMI_VEC      16'h0004
`define IAKR_VEC_BASE     16'h0004
`define IAKR_KEY_PIN_RST  8'hff

`endif

// File: iakr_pkg.sv
// state and register types of the interrupt acknowledge block
package iakr_pkg;

   typedef enum logic [2:0] {
      IAKR_IDLE    = 3'b000,
      IAKR_PSW     = 3'b001,
      IAKR_PC_HIGH = 3'b011,
      IAKR_PC_LOW  = 3'b010,
      IAKR_VECTOR  = 3'b110
   } iakr_state_e;

   typedef struct packed {
      iakr_state_e st;
      logic        ie;
      logic [15:0] flags;
      logic [15:0] masks;
      logic [7:0]  key_sel;
      logic        nmi_pend;
      logic        hold;
      logic [15:0] pc_save;
      logic [15:0] vec;
      logic        push;
      logic [7:0]  sdata;
      logic        pcld;
      logic [7:0]  rdata;
   } iakr_ctrl_s;

   typedef struct packed {
      logic [7:0] prev;
      logic [7:0] pull;
      logic       req;
   } iakr_key_s;

endpackage

// File: iakr_key_detect.sv
// falling edge detector and pull-up control for the eight key-return pins
`include "iakr_cfg.svh"

module iakr_key_detect (
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       sys_rst,
   input  wire logic       clk_en,
   // selection and pins
   input  wire logic [7:0] key_return_pin_select,
   input  wire logic [7:0] key_pin,
   input  wire logic [7:0] port4_is_output,
   // results
   output logic      [7:0] key_pullup_en,
   output logic            key_return_request
);

   iakr_pkg::iakr_key_s r;
   iakr_pkg::iakr_key_s n;
   logic [7:0]          enabled;

   always_comb begin
      // one bit covers the whole low nibble, each upper bit covers one pin
      enabled = {key_return_pin_select[7:4], {4{key_return_pin_select[`IAKR_KRSEL_LOW]}}};
      n       = r;
      n.prev  = key_pin;
      // prev tracks always, so enabling a pin that is already low gives no edge
      n.req   = |(enabled & r.prev & ~key_pin);
      n.pull  = enabled & ~port4_is_output;
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         r.prev <= `IAKR_KEY_PIN_RST;
         r.pull <= 8'h00;
         r.req  <= 1'b0;
      end else if (clk_en) begin
         r <= n;
      end
   end

   assign key_pullup_en      = r.pull;
   assign key_return_request = r.req;

endmodule

// File: iakr_ctrl.sv
// interrupt acknowledge sequencer with request, mask and key-return select registers
//
// What this block does
// - select bit 0 enables the four low key pins; bits 4-7 one upper pin each
// - a set select bit watches its pins for falling edges; clear gives no detection
// - reset clears the key-return select register to zero
// - enabled key pins get a pull-up, except pins driven as outputs
// - non-maskable request ignores the enable flag and beats all maskable requests
// - non-maskable accept pushes status then counter, clears enable, loads its vector
// - a non-maskable request inside a non-maskable routine is still accepted
// - maskable request eligible if flag set and mask clear; vectored only when enabled
// - maskable servicing starts 8 to 19 clocks after the request arises; here the push starts one clock after acceptance at a boundary
// - simultaneous eligible maskable requests are taken one at a time, highest first
// - a pending request is taken as soon as its conditions become true
// - maskable accept pushes status then counter, clears enable, loads own vector
// - a flag raised before an instruction's last clock is taken after that instruction
// - a flag raised in the last clock waits until after the next instruction
// - acceptance waits past any instruction touching request or mask registers
// - maskable nesting only after the routine sets the enable flag again
// - flags set by their source, cleared on acceptance and by reset
// - reset sets both mask registers to all ones
// - maskable priority runs from 0 highest to 10 lowest
`include "iakr_cfg.svh"

module iakr_ctrl #(
   parameter int NUM_SRC = `IAKR_NUM_SRC
) (
   // clock and reset
   input  wire logic               ref_clk,
   input  wire logic               sys_rst,
   input  wire logic               clk_en,
   // memory manipulation port of the core
   input  wire logic [15:0]        mem_addr,
   input  wire logic               mem_wr,
   input  wire logic               mem_rd,
   input  wire logic [7:0]         mem_wdata,
   output logic      [7:0]         mem_rdata,
   // instruction sequencer
   input  wire logic               instr_last_clk,
   input  wire logic               ei_exec,
   input  wire logic               di_exec,
   input  wire logic               return_from_irq_instruction_exec,
   input  wire logic [7:0]         return_from_irq_instruction_psw,
   input  wire logic [7:0]         cpu_psw,
   input  wire logic [15:0]        cpu_pc,
   // request sources
   input  wire logic [NUM_SRC-2:0] src_req,
   input  wire logic               nmi_req,
   // key-return port
   input  wire logic [7:0]         key_pin,
   input  wire logic [7:0]         port4_is_output,
   output logic      [7:0]         key_pullup_en,
   // acknowledge sequence
   output logic                    cpu_stall,
   output logic                    stack_push,
   output logic      [7:0]         stack_data,
   output logic                    pc_load,
   output logic      [15:0]        vec_table_addr,
   output logic                    global_irq_enable_flag
);

   localparam logic [4*`IAKR_NUM_SRC-1:0] POS_TABLE = `IAKR_POS_TABLE;

   iakr_pkg::iakr_ctrl_s r;
   iakr_pkg::iakr_ctrl_s n;

   logic               key_return_request;
   logic [NUM_SRC-1:0] req_all;
   logic [NUM_SRC-1:0] elig;
   logic [15:0]        set_vec;
   logic [15:0]        clr_vec;
   logic [15:0]        wr_flags;
   logic [15:0]        wr_masks;
   logic               flag_access;
   logic               boundary;
   logic               hold_now;
   logic               take_nmi;
   logic               take_mask;
   logic [3:0]         win;

   // bit position of a priority level inside the {reg_b, reg_a} flag pair
   function automatic logic [3:0] flag_pos(input int p);
      flag_pos = POS_TABLE[4*p +: 4];
   endfunction

   // lowest index wins, so priority 0 is served first
   function automatic logic [3:0] first_set(input logic [NUM_SRC-1:0] v);
      first_set = 4'h0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (v[i]) begin
            first_set = 4'(i);
         end
      end
   endfunction

   iakr_key_detect u_key (
      .ref_clk               (ref_clk),
      .sys_rst               (sys_rst),
      .clk_en                (clk_en),
      .key_return_pin_select (r.key_sel),
      .key_pin               (key_pin),
      .port4_is_output       (port4_is_output),
      .key_pullup_en         (key_pullup_en),
      .key_return_request    (key_return_request)
   );

   always_comb begin
      n        = r;
      n.push   = 1'b0;
      n.pcld   = 1'b0;
      req_all  = {key_return_request, src_req};
      set_vec  = 16'h0000;
      clr_vec  = 16'h0000;
      elig     = '0;
      for (int p = 0; p < NUM_SRC; p++) begin
         set_vec[flag_pos(p)] = req_all[p];
         elig[p] = r.flags[flag_pos(p)] & ~r.masks[flag_pos(p)];
      end
      win = first_set(elig);

      flag_access = (mem_wr | mem_rd) &
                    (mem_addr == `IAKR_IFA_ADDR || mem_addr == `IAKR_IFB_ADDR ||
                     mem_addr == `IAKR_MKA_ADDR || mem_addr == `IAKR_MKB_ADDR);
      // acceptance is judged only at an instruction boundary while idle
      // latency in clocks follows from the core's instruction lengths
      boundary  = instr_last_clk & (r.st == iakr_pkg::IAKR_IDLE);
      hold_now  = r.hold | flag_access;
      take_nmi  = boundary & ~hold_now & r.nmi_pend;
      take_mask = boundary & ~hold_now & ~r.nmi_pend & r.ie & (|elig);

      if (boundary) begin
         n.hold = 1'b0;
      end else begin
         n.hold = hold_now;
      end

      if (take_mask) begin
         clr_vec[flag_pos(int'(win))] = 1'b1;
      end

      // register writes; the flag registers take a byte at a time
      wr_flags = r.flags;
      wr_masks = r.masks;
      if (mem_wr) begin
         case (mem_addr)
            `IAKR_IFA_ADDR:   wr_flags[7:0]  = mem_wdata;
            `IAKR_IFB_ADDR:   wr_flags[15:8] = mem_wdata;
            `IAKR_MKA_ADDR:   wr_masks[7:0]  = mem_wdata;
            `IAKR_MKB_ADDR:   wr_masks[15:8] = mem_wdata;
            `IAKR_KRSEL_ADDR: n.key_sel      = mem_wdata & `IAKR_KRSEL_WMASK;
            default: ;
         endcase
      end
      // a source event in the same cycle as a software clear is kept
      n.flags = ((wr_flags & ~clr_vec) | set_vec) & `IAKR_FLAG_USED;
      n.masks = wr_masks | ~`IAKR_FLAG_USED;

      if (take_nmi) begin
         n.nmi_pend = nmi_req;
      end else if (nmi_req) begin
         n.nmi_pend = 1'b1;
      end

      if (return_from_irq_instruction_exec) begin
         n.ie = return_from_irq_instruction_psw[`IAKR_PSW_IE_BIT];
      end else if (ei_exec) begin
         n.ie = 1'b1;
      end else if (di_exec) begin
         n.ie = 1'b0;
      end

      case (r.st)
         iakr_pkg::IAKR_IDLE: begin
            if (take_nmi | take_mask) begin
               n.st      = iakr_pkg::IAKR_PSW;
               n.push    = 1'b1;
               n.sdata   = {r.ie, cpu_psw[6:0]};
               n.pc_save = cpu_pc;
               n.ie      = 1'b0;
               if (take_nmi) begin
                  n.vec = `IAKR_NMI_VEC;
               end else begin
                  n.vec = `IAKR_VEC_BASE + {11'h000, win, 1'b0};
               end
            end
         end
         iakr_pkg::IAKR_PSW: begin
            n.st    = iakr_pkg::IAKR_PC_HIGH;
            n.push  = 1'b1;
            n.sdata = r.pc_save[15:8];
         end
         iakr_pkg::IAKR_PC_HIGH: begin
            n.st    = iakr_pkg::IAKR_PC_LOW;
            n.push  = 1'b1;
            n.sdata = r.pc_save[7:0];
         end
         iakr_pkg::IAKR_PC_LOW: begin
            n.st   = iakr_pkg::IAKR_VECTOR;
            n.pcld = 1'b1;
         end
         iakr_pkg::IAKR_VECTOR: begin
            n.st = iakr_pkg::IAKR_IDLE;
         end
         default: begin
            n.st = iakr_pkg::IAKR_IDLE;
         end
      endcase

      // read data appears one clock after the read strobe
      case (mem_addr)
         `IAKR_IFA_ADDR:   n.rdata = r.flags[7:0];
         `IAKR_IFB_ADDR:   n.rdata = r.flags[15:8];
         `IAKR_MKA_ADDR:   n.rdata = r.masks[7:0];
         `IAKR_MKB_ADDR:   n.rdata = r.masks[15:8];
         `IAKR_KRSEL_ADDR: n.rdata = r.key_sel;
         default:          n.rdata = 8'h00;
      endcase
      if (!mem_rd) begin
         n.rdata = r.rdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         r.st       <= iakr_pkg::IAKR_IDLE;
         r.ie       <= `IAKR_IE_RST;
         r.flags    <= `IAKR_IF_RST;
         r.masks    <= `IAKR_MK_RST;
         r.key_sel  <= `IAKR_KRSEL_RST;
         r.nmi_pend <= 1'b0;
         r.hold     <= 1'b0;
         r.pc_save  <= 16'h0000;
         r.vec      <= 16'h0000;
         r.push     <= 1'b0;
         r.sdata    <= 8'h00;
         r.pcld     <= 1'b0;
         r.rdata    <= 8'h00;
      end else if (clk_en) begin
         r <= n;
      end
   end

   // the core freezes while the push and vector steps run
   assign cpu_stall              = (r.st != iakr_pkg::IAKR_IDLE);
   assign stack_push             = r.push;
   assign stack_data             = r.sdata;
   assign pc_load                = r.pcld;
   assign vec_table_addr         = r.vec;
   assign mem_rdata              = r.rdata;
   assign global_irq_enable_flag = r.ie;

endmodule

// File: iakr_ctrl_props.sv
// port assertions of the interrupt acknowledge block
`include "iakr_cfg.svh"

module iakr_ctrl_props #(
   parameter int NUM_SRC = `IAKR_NUM_SRC
) (
   input wire logic               ref_clk, sys_rst, clk_en, mem_wr, mem_rd, instr_last_clk,
   input wire logic               ei_exec, di_exec, return_from_irq_instruction_exec, nmi_req,
   input wire logic [15:0]        mem_addr, cpu_pc, vec_table_addr,
   input wire logic [7:0]         mem_wdata, mem_rdata, return_from_irq_instruction_psw, cpu_psw, key_pin,
   input wire logic [7:0]         port4_is_output, key_pullup_en, stack_data,
   input wire logic [NUM_SRC-2:0] src_req,
   input wire logic               cpu_stall, stack_push, pc_load, global_irq_enable_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   AST_STALL_LEN: assert property ($rose(cpu_stall) |-> cpu_stall[*4] ##1 !cpu_stall)
      else $error("acknowledge stall not four cycles");
   AST_PUSH_SEQ: assert property ($rose(cpu_stall) |-> stack_push[*3] ##1 (pc_load && !stack_push))
      else $error("push order broken");
   AST_PSW_IE: assert property ($rose(cpu_stall) |-> stack_data[7] == $past(global_irq_enable_flag))
      else $error("pushed status enable bit wrong");
   AST_PC_BYTES: assert property ($rose(cpu_stall) |-> ##1 stack_data == $past(cpu_pc[15:8], 2)
      ##1 stack_data == $past(cpu_pc[7:0], 3))
      else $error("pushed counter bytes wrong");
   AST_IE_CLR: assert property ($rose(cpu_stall) && !$past(ei_exec) && !$past(return_from_irq_instruction_exec)
      |-> !global_irq_enable_flag)
      else $error("enable flag not cleared on acceptance");
   AST_NMI_ONLY: assert property ($rose(cpu_stall) && !$past(global_irq_enable_flag)
      |-> vec_table_addr == `IAKR_NMI_VEC)
      else $error("maskable taken while disabled");
   AST_BOUNDARY: assert property ($rose(cpu_stall) |-> $past(instr_last_clk))
      else $error("acceptance off an instruction boundary");
   AST_HOLD: assert property (clk_en && instr_last_clk && (mem_wr || mem_rd)
      && mem_addr[15:3] == 13'h1ffc && !mem_addr[1] |=> !cpu_stall)
      else $error("acceptance during flag register access");
   AST_VEC_HOLD: assert property (!cpu_stall |-> $stable(vec_table_addr))
      else $error("vector changed outside acknowledge");
   AST_PULL_OUT: assert property ($stable(port4_is_output) |-> (key_pullup_en & port4_is_output) == 8'h00)
      else $error("pull-up on output pin");
   AST_SEL_RSV: assert property (clk_en && mem_rd && mem_addr == `IAKR_KRSEL_ADDR |=> mem_rdata[3:1] == 3'h0)
      else $error("unused select bits read nonzero");
endmodule

bind iakr_ctrl iakr_ctrl_props #(.NUM_SRC(NUM_SRC)) u_props (.*);

// File: iakr_core_model.sv
// instruction sequencer of the core, frozen while an acknowledge runs
module iakr_core_model #(
   parameter int ILEN = 4
) (
   input wire logic ref_clk, sys_rst, cpu_stall,
   output logic     instr_last_clk
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt;
   // boundaries only every ILEN clocks, so late requests wait a whole instruction
   always_ff @(posedge ref_clk) begin
      if (sys_rst || instr_last_clk) cnt <= 4'h0;
      else if (!cpu_stall) cnt <= cnt + 4'h1;
   end
   assign instr_last_clk = (cnt == 4'(ILEN - 1)) && !cpu_stall;
endmodule

// File: iakr_ctrl_tb.sv
// self-checking bench of the interrupt acknowledge block
module iakr_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk, sys_rst, mem_wr, mem_rd, ei_exec, return_from_irq_instruction_exec, nmi_req, instr_last_clk;
   logic        cpu_stall, stack_push, pc_load, global_irq_enable_flag;
   logic [15:0] mem_addr, vec_table_addr;
   logic [7:0]  mem_wdata, mem_rdata, key_pin, port4_is_output, key_pullup_en, stack_data;
   logic [9:0]  src_req;
   int          error_cnt = 0, samples_checked = 0, cyc = 0;

   iakr_ctrl uut (.*, .clk_en(1'b1), .di_exec(1'b0), .return_from_irq_instruction_psw(8'h80), .cpu_psw(8'h45), .cpu_pc(16'ha5c3));
   iakr_core_model core (.ref_clk, .sys_rst, .cpu_stall, .instr_last_clk);

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   task automatic final_report;
      if (error_cnt == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // generous ceiling, the whole run needs under two hundred cycles
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         final_report;
      end
   end

   task automatic chk(input logic [15:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic go(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      go(1);
      s = 1'b0;
      // one idle cycle, so a following call never re-raises this strobe in the same step
      go(1);
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      mem_addr = a;
      mem_wdata = d;
      pulse(mem_wr);
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      mem_addr = a;
      pulse(mem_rd);
      chk({8'h00, mem_rdata}, {8'h00, e});
   endtask
   task automatic none(input int n);
      repeat (n) begin
         go(1);
         chk({15'h0000, stack_push}, 16'h0000);
      end
   endtask
   // waits for the push burst, then checks status, counter bytes and vector
   task automatic ack(input logic [15:0] v, input logic e);
      int n;
      n = 0;
      while (stack_push !== 1'b1 && n < 60) begin
         go(1);
         n++;
      end
      chk({8'h00, stack_data}, {8'h00, e, 7'h45});
      go(1);
      chk({8'h00, stack_data}, 16'h00a5);
      go(1);
      chk({8'h00, stack_data}, 16'h00c3);
      go(1);
      chk({15'h0000, pc_load}, 16'h0001);
      chk(vec_table_addr, v);
   endtask

   initial begin
      {mem_wr, mem_rd, ei_exec, return_from_irq_instruction_exec, nmi_req, src_req} = '0;
      mem_addr = 16'h0000;
      mem_wdata = 8'h00;
      key_pin = 8'hff;
      port4_is_output = 8'h00;
      sys_rst = 1'b1;
      go(6);
      sys_rst = 1'b0;
      rd(16'hfff5, 8'h00);
      rd(16'hffe4, 8'hff);
      rd(16'hffe5, 8'hff);
      rd(16'hffe1, 8'h00);
      rd(16'h0100, 8'h00);
      wr(16'hfff5, 8'hf1);
      rd(16'hfff5, 8'hf1);
      go(1);
      chk({8'h00, key_pullup_en}, 16'h00ff);
      port4_is_output = 8'h0f;
      go(2);
      chk({8'h00, key_pullup_en}, 16'h00f0);
      wr(16'hffe4, 8'hef);
      pulse(ei_exec);
      chk({15'h0000, global_irq_enable_flag}, 16'h0001);
      key_pin = 8'hdf;
      ack(16'h0018, 1'b1);
      rd(16'hffe0, 8'h00);
      key_pin = 8'hff;
      wr(16'hffe4, 8'hff);
      wr(16'hfff5, 8'h10);
      wr(16'hffe0, 8'h00);
      wr(16'hffe4, 8'hef);
      pulse(ei_exec);
      key_pin = 8'hd0;
      none(30);
      key_pin = 8'hc0;
      ack(16'h0018, 1'b1);
      pulse(nmi_req);
      ack(16'h0004, 1'b0);
      wr(16'hffe5, 8'hdb);
      src_req = 10'h024;
      go(1);
      src_req = 10'h000;
      none(20);
      rd(16'hffe1, 8'h24);
      pulse(return_from_irq_instruction_exec);
      ack(16'h0008, 1'b1);
      chk({15'h0000, global_irq_enable_flag}, 16'h0000);
      none(20);
      pulse(ei_exec);
      ack(16'h000e, 1'b1);
      final_report;
   end
endmodule
